//--- shared/uart_regs_pkg.sv
// Register map, field positions and rate constants of the serial data and bit-rate block
`default_nettype none
package uart_regs_pkg;
    localparam int ADDR_W = 3;
    localparam int CHAR_W = 9;
    localparam int RX_DEPTH = 16;

    // Register indexes on the local register port
    localparam logic [2:0] OFS_RX_CTRL = 3'h0;
    localparam logic [2:0] OFS_TX_CTRL = 3'h1;
    localparam logic [2:0] OFS_RATE_CTRL = 3'h2;
    localparam logic [2:0] OFS_RX_DATA = 3'h3;
    localparam logic [2:0] OFS_TX_DATA = 3'h4;
    localparam logic [2:0] OFS_DIV_LO = 3'h5;
    localparam logic [2:0] OFS_DIV_HI = 3'h6;
    localparam logic [2:0] OFS_BUF_STAT = 3'h7;

    // serial_transmit_control fields
    localparam int TXC_ENABLE = 5;
    localparam int TXC_SYNC = 4;
    localparam int TXC_HIGH_SPEED = 2;
    localparam int TXC_SHIFT_EMPTY = 1;
    localparam int TXC_NINTH_BIT = 0;
    localparam int TXC_NINTH_EN = 6;
    localparam logic [7:0] TXC_WR_MASK = 8'hfd;

    // serial_receive_control fields
    localparam int RXC_PORT_EN = 7;
    localparam int RXC_NINTH_EN = 6;
    localparam int RXC_CONT_EN = 4;
    localparam int RXC_OVERRUN = 1;
    localparam int RXC_NINTH_BIT = 0;
    localparam logic [7:0] RXC_WR_MASK = 8'hf8;

    // bit_rate_control fields
    localparam int RTC_IDLE = 6;
    localparam int RTC_WIDE = 3;
    localparam logic [7:0] RTC_WR_MASK = 8'h1b;

    // Buffer status fields
    localparam int BST_RX_VALID = 0;
    localparam int BST_TX_EMPTY = 1;

    localparam logic [7:0] REG_RESET = 8'h00;

    // Clocks per divisor step for each rate formula
    localparam int PRE_W = 7;
    localparam logic [6:0] PRE_SLOW = 7'h40;
    localparam logic [6:0] PRE_MID = 7'h10;
    localparam logic [6:0] PRE_FAST = 7'h04;
endpackage : uart_regs_pkg
`default_nettype wire

//--- design/char_fifo.sv
// Character FIFO with registered head word, valid and ready on both sides
`default_nettype none
module char_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] FULL_COUNT = (PTR_W+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [PTR_W-1:0] rd_ptr_d;
    logic [PTR_W:0] count_q;
    logic [PTR_W:0] count_d;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
    assign count_d = count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_d;
        end
    end

    // Flags and head are registered so the consumer sees settled values
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_ready <= 1'b1;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            in_ready <= count_d != FULL_COUNT;
            out_valid <= count_d != '0;
            // Bypass when the word just written becomes the head
            if (push && wr_ptr_q == rd_ptr_d) begin
                out_data <= in_data;
            end else begin
                out_data <= mem[rd_ptr_d];
            end
        end
    end
endmodule : char_fifo
`default_nettype wire

//--- design/uart_data_rate.sv
// Serial port data holding registers and bit-rate generator
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Function
// [R01] Receive data register is read-only, low eight bits; ninth bit in receive control.
// [R02] Received characters, ninth bit included, stay readable while next arrives.
// [R03] Transmit holding, ninth bit included, takes a write once previous starts shifting.
// [R04] Writing divisor low byte stores bits 7:0 and restarts rate counter.
// [R05] Writing divisor high byte stores bits 15:8 and restarts rate counter.
// [R06] High divisor byte ignored unless wide divisor selected.
// [R07] Rate divides clock by 64(n+1) narrow slow, 16(n+1) wide slow, 4(n+1) synchronous.
// [R08] High-speed asynchronous: 16(n+1) narrow, 4(n+1) wide.
// [R09] Wide select chooses sixteen-bit divisor, else eight-bit.
// [R10] High-speed select matters only in asynchronous mode.
// [R11] Sync-mode select chooses synchronous or asynchronous rate formula.
module uart_data_rate (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [uart_regs_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic rx_char_valid,
    input wire logic [uart_regs_pkg::CHAR_W-1:0] rx_char_data,
    output logic rx_char_ready,
    output logic tx_char_valid,
    output logic [uart_regs_pkg::CHAR_W-1:0] tx_char_data,
    input wire logic tx_char_start,
    input wire logic shift_empty,
    input wire logic rx_idle,
    output logic bit_tick,
    output logic port_enable,
    output logic sync_mode,
    output logic tx_enable,
    output logic rx_enable,
    output logic tx_ninth_enable,
    output logic rx_ninth_enable
);
    //////////////////////////////////////////////////////////////////////////
    // Control registers
    logic [7:0] rx_ctrl_q;
    logic [7:0] tx_ctrl_q;
    logic [7:0] rate_ctrl_q;
    logic [7:0] div_lo_q;
    logic [7:0] div_hi_q;
    logic overrun_q;
    logic wr_rx_ctrl;
    logic wr_tx_ctrl;
    logic wr_rate_ctrl;
    logic wr_div_lo;
    logic wr_div_hi;
    logic wr_tx_data;
    logic div_wr;

    assign wr_rx_ctrl = reg_wr && reg_addr == uart_regs_pkg::OFS_RX_CTRL;
    assign wr_tx_ctrl = reg_wr && reg_addr == uart_regs_pkg::OFS_TX_CTRL;
    assign wr_rate_ctrl = reg_wr && reg_addr == uart_regs_pkg::OFS_RATE_CTRL;
    assign wr_div_lo = reg_wr && reg_addr == uart_regs_pkg::OFS_DIV_LO;
    assign wr_div_hi = reg_wr && reg_addr == uart_regs_pkg::OFS_DIV_HI;
    assign wr_tx_data = reg_wr && reg_addr == uart_regs_pkg::OFS_TX_DATA;
    assign div_wr = wr_div_lo || wr_div_hi;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_ctrl_q <= uart_regs_pkg::REG_RESET;
            tx_ctrl_q <= uart_regs_pkg::REG_RESET;
            rate_ctrl_q <= uart_regs_pkg::REG_RESET;
        end else begin
            if (wr_rx_ctrl) begin
                rx_ctrl_q <= reg_wdata & uart_regs_pkg::RXC_WR_MASK;
            end
            if (wr_tx_ctrl) begin
                tx_ctrl_q <= reg_wdata & uart_regs_pkg::TXC_WR_MASK;
            end
            if (wr_rate_ctrl) begin
                rate_ctrl_q <= reg_wdata & uart_regs_pkg::RTC_WR_MASK;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_lo_q <= uart_regs_pkg::REG_RESET;
            div_hi_q <= uart_regs_pkg::REG_RESET;
        end else begin
            if (wr_div_lo) begin
                div_lo_q <= reg_wdata; // R04
            end
            if (wr_div_hi) begin
                div_hi_q <= reg_wdata; // R05
            end
        end
    end

    assign port_enable = rx_ctrl_q[uart_regs_pkg::RXC_PORT_EN];
    assign rx_enable = rx_ctrl_q[uart_regs_pkg::RXC_CONT_EN];
    assign rx_ninth_enable = rx_ctrl_q[uart_regs_pkg::RXC_NINTH_EN];
    assign sync_mode = tx_ctrl_q[uart_regs_pkg::TXC_SYNC];
    assign tx_enable = tx_ctrl_q[uart_regs_pkg::TXC_ENABLE];
    assign tx_ninth_enable = tx_ctrl_q[uart_regs_pkg::TXC_NINTH_EN];

    //////////////////////////////////////////////////////////////////////////
    // Bit-rate generator
    logic wide_divisor_select;
    logic high_speed_select;
    logic [15:0] div_eff;
    logic [uart_regs_pkg::PRE_W-1:0] pre_sel;
    logic [uart_regs_pkg::PRE_W-1:0] pre_cnt_q;
    logic [15:0] div_cnt_q;
    logic pre_wrap;

    assign wide_divisor_select = rate_ctrl_q[uart_regs_pkg::RTC_WIDE];
    assign high_speed_select = tx_ctrl_q[uart_regs_pkg::TXC_HIGH_SPEED];
    assign div_eff = wide_divisor_select ? {div_hi_q, div_lo_q} : {8'h00, div_lo_q}; // R06 R09

    always_comb begin
        if (sync_mode) begin
            pre_sel = uart_regs_pkg::PRE_FAST; // R07 R10 R11
        end else if (wide_divisor_select && high_speed_select) begin
            pre_sel = uart_regs_pkg::PRE_FAST; // R08
        end else if (wide_divisor_select || high_speed_select) begin
            pre_sel = uart_regs_pkg::PRE_MID; // R07 R08
        end else begin
            pre_sel = uart_regs_pkg::PRE_SLOW; // R07
        end
    end

    // Compare with >= so a mode change mid-count cannot strand the counter
    assign pre_wrap = pre_cnt_q >= pre_sel - 1'b1;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_cnt_q <= '0;
        end else if (div_wr) begin
            pre_cnt_q <= '0; // R04 R05
        end else if (pre_wrap) begin
            pre_cnt_q <= '0;
        end else begin
            pre_cnt_q <= pre_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt_q <= '0;
        end else if (div_wr) begin
            div_cnt_q <= '0; // R04 R05
        end else if (pre_wrap) begin
            div_cnt_q <= (div_cnt_q >= div_eff) ? 16'h0000 : div_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bit_tick <= 1'b0;
        end else begin
            bit_tick <= !div_wr && pre_wrap && div_cnt_q >= div_eff; // R07
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Receive path: shifter hands characters into the FIFO, head is the holding register
    logic rx_head_valid;
    logic [uart_regs_pkg::CHAR_W-1:0] rx_head;
    logic rx_push;
    logic rx_pop;

    assign rx_push = rx_char_valid && port_enable && rx_enable;
    assign rx_pop = reg_rd && reg_addr == uart_regs_pkg::OFS_RX_DATA;

    char_fifo #(
        .WIDTH(uart_regs_pkg::CHAR_W),
        .DEPTH(uart_regs_pkg::RX_DEPTH)
    ) rx_fifo (
        .clk(core_clk),
        .rst(sys_rst),
        .in_valid(rx_push),
        .in_data(rx_char_data),
        .in_ready(rx_char_ready),
        .out_valid(rx_head_valid),
        .out_data(rx_head),
        .out_ready(rx_pop)
    ); // R02

    // Overrun clears only by dropping continuous receive; a new overrun wins over the clear
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            overrun_q <= 1'b0;
        end else if (rx_push && !rx_char_ready) begin
            overrun_q <= 1'b1;
        end else if (wr_rx_ctrl && !reg_wdata[uart_regs_pkg::RXC_CONT_EN]) begin
            overrun_q <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Transmit holding register
    logic tx_accept;

    // A write while the holding register is still full is dropped
    assign tx_accept = wr_tx_data && (!tx_char_valid || tx_char_start); // R03

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_char_valid <= 1'b0;
            tx_char_data <= '0;
        end else if (tx_accept) begin
            tx_char_valid <= 1'b1; // R03
            tx_char_data <= {tx_ctrl_q[uart_regs_pkg::TXC_NINTH_BIT], reg_wdata};
        end else if (tx_char_start) begin
            tx_char_valid <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Read port
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        case (reg_addr)
            uart_regs_pkg::OFS_RX_CTRL: begin
                rd_mux = rx_ctrl_q;
                rd_mux[uart_regs_pkg::RXC_OVERRUN] = overrun_q;
                rd_mux[uart_regs_pkg::RXC_NINTH_BIT] = rx_head[uart_regs_pkg::CHAR_W-1]; // R01
            end
            uart_regs_pkg::OFS_TX_CTRL: begin
                rd_mux = tx_ctrl_q;
                rd_mux[uart_regs_pkg::TXC_SHIFT_EMPTY] = shift_empty;
            end
            uart_regs_pkg::OFS_RATE_CTRL: begin
                rd_mux = rate_ctrl_q;
                rd_mux[uart_regs_pkg::RTC_IDLE] = rx_idle;
            end
            uart_regs_pkg::OFS_RX_DATA: rd_mux = rx_head[7:0]; // R01
            uart_regs_pkg::OFS_TX_DATA: rd_mux = tx_char_data[7:0];
            uart_regs_pkg::OFS_DIV_LO: rd_mux = div_lo_q;
            uart_regs_pkg::OFS_DIV_HI: rd_mux = div_hi_q;
            uart_regs_pkg::OFS_BUF_STAT: begin
                rd_mux[uart_regs_pkg::BST_RX_VALID] = rx_head_valid;
                rd_mux[uart_regs_pkg::BST_TX_EMPTY] = !tx_char_valid;
            end
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks
    logic [23:0] gap_cnt_q;
    logic clean_q;
    logic cfg_chg;

    // Period check only counts ticks with untouched divisor and mode
    assign cfg_chg = div_wr || wr_tx_ctrl || wr_rate_ctrl;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gap_cnt_q <= 24'h000001;
            clean_q <= 1'b0;
        end else begin
            gap_cnt_q <= bit_tick ? 24'h000001 : gap_cnt_q + 1'b1;
            if (cfg_chg) begin
                clean_q <= 1'b0;
            end else if (bit_tick) begin
                clean_q <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    AST_RX_DATA_READ: assert property ((reg_rd && reg_addr == uart_regs_pkg::OFS_RX_DATA) // R01
        |=> reg_rdata == $past(rx_head[7:0]))
        else $error("receive data read does not show the head character");
    AST_RX_HEAD_HOLD: assert property ((rx_head_valid && !rx_pop) |=> rx_head_valid && $stable(rx_head)) // R02
        else $error("held receive character changed without a read");
    AST_TX_ACCEPT: assert property ((wr_tx_data && (!tx_char_valid || tx_char_start)) // R03
        |=> tx_char_valid && tx_char_data[7:0] == $past(reg_wdata))
        else $error("transmit write not taken into the holding register");
    AST_DIV_LO_RESTART: assert property (wr_div_lo |=> pre_cnt_q == '0 && div_cnt_q == '0 // R04
        && div_lo_q == $past(reg_wdata) && !bit_tick)
        else $error("low divisor write did not restart the counter");
    AST_DIV_HI_RESTART: assert property (wr_div_hi |=> pre_cnt_q == '0 && div_cnt_q == '0 // R05
        && div_hi_q == $past(reg_wdata))
        else $error("high divisor write did not restart the counter");
    AST_NARROW_IGNORES_HI: assert property (!wide_divisor_select |-> div_eff[15:8] == 8'h00) // R06
        else $error("high divisor byte used while narrow");
    AST_WIDE_USES_HI: assert property (wide_divisor_select |-> div_eff == {div_hi_q, div_lo_q}) // R09
        else $error("wide divisor not formed from both bytes");
    AST_SLOW_PERIOD: assert property ((bit_tick && clean_q && !sync_mode && !wide_divisor_select // R07
        && !high_speed_select) |-> gap_cnt_q == 24'(div_eff) * 24'd64 + 24'd64)
        else $error("narrow low-speed period is not 64(n+1)");
    AST_PERIOD: assert property ((bit_tick && clean_q) |-> gap_cnt_q == 24'(pre_sel) * (24'(div_eff) + 24'd1)) // R07
        else $error("bit period does not match the selected formula");
    AST_HIGH_SPEED_DIV: assert property ((!sync_mode && high_speed_select) // R08
        |-> pre_sel == (wide_divisor_select ? uart_regs_pkg::PRE_FAST : uart_regs_pkg::PRE_MID))
        else $error("high-speed prescale wrong");
    AST_SYNC_IGNORES_HS: assert property (sync_mode |-> pre_sel == uart_regs_pkg::PRE_FAST) // R10
        else $error("synchronous mode rate depends on high-speed select");
    AST_MODE_SELECT: assert property ((!sync_mode && !high_speed_select && wide_divisor_select) // R11
        |-> pre_sel == uart_regs_pkg::PRE_MID)
        else $error("asynchronous wide low-speed prescale wrong");

    // Register port, holding registers and counter hazards
    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00) // R01
        else $error("read data not zero outside a read");
    AST_NINTH_SHOWN: assert property ((reg_rd && reg_addr == uart_regs_pkg::OFS_RX_CTRL) // R01
        |=> reg_rdata[uart_regs_pkg::RXC_NINTH_BIT] == $past(rx_head[uart_regs_pkg::CHAR_W-1]))
        else $error("ninth bit not shown in receive control");
    AST_RX_FIRST_SHOWN: assert property ((rx_push && rx_char_ready && !rx_head_valid) // R02
        |=> rx_head_valid && rx_head == $past(rx_char_data))
        else $error("first character not at the head");
    AST_OVERRUN_SET: assert property ((rx_push && !rx_char_ready) |=> overrun_q) // R02
        else $error("refused character did not flag an overrun");
    AST_TX_REFUSED: assert property ((wr_tx_data && tx_char_valid && !tx_char_start) // R03
        |=> tx_char_valid && $stable(tx_char_data))
        else $error("write into a full holding register was taken");
    AST_TX_RELEASE: assert property ((tx_char_start && !wr_tx_data) |=> !tx_char_valid) // R03
        else $error("holding register still full after shifting began");
    AST_DIV_LO_ONLY: assert property (wr_div_lo |=> $stable(div_hi_q)) // R04
        else $error("low divisor write changed the high byte");
    AST_DIV_HI_ONLY: assert property (wr_div_hi |=> $stable(div_lo_q)) // R05
        else $error("high divisor write changed the low byte");
    // Shortest period is four clocks, so a tick never lasts two cycles
    AST_TICK_PULSE: assert property (bit_tick |=> !bit_tick) // R07
        else $error("bit tick longer than one cycle");

    COV_TICK_SYNC: cover property (bit_tick && clean_q && sync_mode);
    COV_RX_FULL: cover property (rx_char_valid && !rx_char_ready);
    COV_TX_BACK_TO_BACK: cover property (tx_char_start && wr_tx_data);
    COV_WIDE_HS: cover property (bit_tick && clean_q && wide_divisor_select && high_speed_select);
    COV_OVERRUN_CLEAR: cover property (overrun_q && wr_rx_ctrl);
endmodule : uart_data_rate
`default_nettype wire

//--- bench/serial_peer_model.sv
// Behavioural shifter on the line side: offers received characters and takes transmit characters
`default_nettype none
module serial_peer_model #(
    parameter int SHIFT_CYC = 20
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic tx_char_valid,
    input wire logic [8:0] tx_char_data,
    output logic rx_char_valid,
    output logic [8:0] rx_char_data,
    output logic tx_char_start,
    output logic shift_empty,
    output logic rx_idle
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] rxq[$];
    logic [8:0] txq[$];
    int busy;

    task automatic send(input logic [8:0] c);
        rxq.push_back(c);
    endtask : send

    ////////////////////////////////////////////////////////////////////////////
    // A character is offered for one cycle only: a full buffer loses it, as on a real line
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_char_valid <= 1'b0;
            rx_char_data <= 9'h000;
            rx_idle <= 1'b1;
            tx_char_start <= 1'b0;
            busy <= 0;
        end else begin
            if (rxq.size() > 0) begin
                rx_char_valid <= 1'b1;
                rx_idle <= 1'b0;
                rx_char_data <= rxq.pop_front();
            end else begin
                rx_char_valid <= 1'b0;
                rx_idle <= 1'b1;
                rx_char_data <= ~rx_char_data;
            end
            tx_char_start <= 1'b0;
            if (busy > 0) begin
                busy <= busy - 1;
            end
            if (tx_char_valid && tx_char_start) begin
                txq.push_back(tx_char_data);
                busy <= SHIFT_CYC;
            end else if (tx_char_valid && busy == 0) begin
                tx_char_start <= 1'b1;
            end
        end
    end

    assign shift_empty = (busy == 0);
endmodule : serial_peer_model
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking bench for the serial data holding and bit-rate block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, sys_rst, reg_wr, reg_rd;
    logic [uart_regs_pkg::ADDR_W-1:0] reg_addr;
    logic [7:0] reg_wdata;
    wire logic [7:0] reg_rdata;
    wire logic rx_char_valid, rx_char_ready, tx_char_valid, tx_char_start, shift_empty, rx_idle, bit_tick;
    wire logic [8:0] rx_char_data, tx_char_data;
    wire logic port_enable, sync_mode, tx_enable, rx_enable, tx_ninth_enable, rx_ninth_enable;
    int fails;
    int compares;

    uart_data_rate dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_char_valid(rx_char_valid),
        .rx_char_data(rx_char_data), .rx_char_ready(rx_char_ready), .tx_char_valid(tx_char_valid),
        .tx_char_data(tx_char_data), .tx_char_start(tx_char_start), .shift_empty(shift_empty),
        .rx_idle(rx_idle), .bit_tick(bit_tick), .port_enable(port_enable), .sync_mode(sync_mode),
        .tx_enable(tx_enable), .rx_enable(rx_enable), .tx_ninth_enable(tx_ninth_enable),
        .rx_ninth_enable(rx_ninth_enable));

    serial_peer_model peer_u (.core_clk(core_clk), .sys_rst(sys_rst), .tx_char_valid(tx_char_valid),
        .tx_char_data(tx_char_data), .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
        .tx_char_start(tx_char_start), .shift_empty(shift_empty), .rx_idle(rx_idle));

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (fails == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic chk_reg(input logic [2:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        compares++;
        if (reg_rdata !== e) begin
            fails++;
            $display("unexpected at %0t: register %0d read %h, wanted %h", $time, a, reg_rdata, e);
        end
    endtask : chk_reg

    task automatic chk_bits(input logic [8:0] g, input logic [8:0] e);
        compares++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: port value %h, wanted %h", $time, g, e);
        end
    endtask : chk_bits

    task automatic chk_cnt(input int g, input int e);
        compares++;
        if (g != e) begin
            fails++;
            $display("unexpected at %0t: count %0d, wanted %0d", $time, g, e);
        end
    endtask : chk_cnt

    // Last divisor write restarts the counter: first tick one period after it, then steady
    task automatic rate_case(input logic sy, input logic hs, input logic wide, input logic [7:0] lo,
        input logic [7:0] hi, input logic hi_last, input int p);
        int first;
        int second;
        first = 0;
        second = 0;
        wr(3'h1, {3'h0, sy, 1'b0, hs, 2'h0});
        wr(3'h2, {4'h0, wide, 3'h0});
        if (hi_last) begin
            wr(3'h5, lo);
            wr(3'h6, hi);
        end else begin
            wr(3'h6, hi);
            wr(3'h5, lo);
        end
        for (int k = 1; k <= 2 * p + 4; k++) begin
            @(posedge core_clk);
            #1;
            if (bit_tick === 1'b1) begin
                if (first == 0) begin
                    first = k;
                end else begin
                    second = k;
                    break;
                end
            end
        end
        chk_cnt(first, p);
        chk_cnt(second - first, p);
    endtask : rate_case

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    initial begin
        #3_000_000;
        fails++;
        report_and_stop();
    end

    initial begin
        fails = 0;
        compares = 0;
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        chk_bits({7'h00, rx_char_ready, tx_char_valid}, 9'h002);
        chk_reg(3'h0, 8'h00);
        chk_reg(3'h1, 8'h02);
        chk_reg(3'h2, 8'h40);
        chk_reg(3'h3, 8'h00);
        chk_reg(3'h4, 8'h00);
        chk_reg(3'h5, 8'h00);
        chk_reg(3'h6, 8'h00);
        chk_reg(3'h7, 8'h02);
        // Writable masks, read-only bits and the control outputs
        wr(3'h0, 8'hff);
        wr(3'h1, 8'hff);
        wr(3'h2, 8'hff);
        wr(3'h5, 8'hff);
        wr(3'h6, 8'hff);
        wr(3'h3, 8'h55);
        chk_bits({3'h0, port_enable, rx_enable, rx_ninth_enable, sync_mode, tx_enable, tx_ninth_enable}, 9'h03f);
        chk_reg(3'h0, 8'hf8);
        chk_reg(3'h1, 8'hff);
        chk_reg(3'h2, 8'h5b);
        chk_reg(3'h3, 8'h00);
        chk_reg(3'h5, 8'hff);
        chk_reg(3'h6, 8'hff);
        // Characters queue up behind the one being read, ninth bit with each
        wr(3'h0, 8'h90);
        peer_u.send(9'h1a5);
        peer_u.send(9'h03c);
        peer_u.send(9'h1ff);
        repeat (6) @(posedge core_clk);
        chk_reg(3'h7, 8'h03);
        chk_reg(3'h0, 8'h91);
        chk_reg(3'h3, 8'ha5);
        chk_reg(3'h0, 8'h90);
        chk_reg(3'h3, 8'h3c);
        chk_reg(3'h0, 8'h91);
        chk_reg(3'h3, 8'hff);
        chk_reg(3'h7, 8'h02);
        // Seventeen back to back: the last is refused and flags an overrun
        for (int i = 0; i < 17; i++) begin
            peer_u.send(9'(16 + i));
        end
        repeat (24) @(posedge core_clk);
        chk_bits({8'h00, rx_char_ready}, 9'h000);
        chk_reg(3'h0, 8'h92);
        for (int i = 0; i < 16; i++) begin
            chk_reg(3'h3, 8'(16 + i));
        end
        chk_reg(3'h7, 8'h02);
        wr(3'h0, 8'h80);
        chk_reg(3'h0, 8'h80);
        // Second write lands on the start edge, third finds the holding register full
        wr(3'h1, 8'h21);
        wr(3'h4, 8'ha5);
        wr(3'h4, 8'h3c);
        wr(3'h4, 8'h77);
        chk_reg(3'h7, 8'h00);
        repeat (40) @(posedge core_clk);
        wr(3'h1, 8'h20);
        wr(3'h4, 8'h5a);
        repeat (30) @(posedge core_clk);
        chk_cnt(peer_u.txq.size(), 3);
        chk_bits(peer_u.txq[0], 9'h1a5);
        chk_bits(peer_u.txq[1], 9'h13c);
        chk_bits(peer_u.txq[2], 9'h05a);
        chk_bits({8'h00, tx_char_valid}, 9'h000);
        chk_reg(3'h7, 8'h02);
        // Every rate formula, with the high byte both ignored and used
        rate_case(1'b0, 1'b0, 1'b0, 8'h02, 8'hff, 1'b0, 192);
        rate_case(1'b0, 1'b1, 1'b0, 8'h05, 8'h01, 1'b1, 96);
        rate_case(1'b0, 1'b0, 1'b1, 8'h02, 8'h01, 1'b0, 4144);
        rate_case(1'b0, 1'b1, 1'b1, 8'h09, 8'h00, 1'b1, 40);
        rate_case(1'b1, 1'b1, 1'b0, 8'h07, 8'h03, 1'b0, 32);
        rate_case(1'b1, 1'b0, 1'b1, 8'h00, 8'h01, 1'b1, 1028);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
